// File: logic/pag_guard.v
// parameter access guard: write policy, rotation inhibit, visibility, panel stop
//
// Contract
// - policy 0: writes only while stopped in keypad mode.
// - policy 1: all writes refused, reads still served.
// - policy 1: parameter clear and all-parameter clear refused.
// - policy 1: fixed exception set still writable.
// - policy 2: writes accepted in every mode, running or stopped.
// - policy 2: listed parameters still refused while running.
// - write policy parameter writable in any mode and run state.
// - policy and rotation inhibit settable only with extended visibility.
// - rotation inhibit 0 both, 1 no reverse, 2 no forward.
// - rotation inhibit gates keys, start terminals and serial commands.
// - visibility default shows simple subset; zero shows all to units.
// - visibility changeable during operation, even under stop-only policy.
// - serial reads see everything unless command source selection is two.
// - with external unit fitted, jog and contrast count as simple.
// - panel stop also cleared by power reset or fault-clear input.
// - keypad stop in external mode ramps down even if coasting chosen.
// - keypad mode: stop from non-selected unit enters panel stop.
// - source selection default: external unit wins over built-in panel.
// - reset selection 0..3: no panel stop, stop key only in keypad mode.
`include "pag_defs.vh"
module pag_guard (
   // clock and reset
   input wire core_clk,
   input wire srst,
   // parameter access request
   input wire req_valid,
   input wire req_write,
   input wire req_clear,
   input wire req_all_clear,
   input wire [1:0] req_src,
   input wire [9:0] req_pnum,
   input wire [15:0] req_wdata,
   // access answer
   output reg rsp_valid_r,
   output reg rsp_err_r,
   output reg [15:0] rsp_rdata_r,
   // outer parameter store
   input wire [15:0] store_rdata,
   output reg store_we_r,
   output reg [9:0] store_pnum_r,
   output reg [15:0] store_wdata_r,
   output reg param_clear_r,
   output reg all_clear_r,
   // drive status
   input wire motor_running,
   input wire [1:0] op_mode,
   input wire unit_fitted,
   input wire fault_clear_input,
   // direction command sources
   input wire panel_fwd_key,
   input wire panel_rev_key,
   input wire unit_fwd_key,
   input wire unit_rev_key,
   input wire forward_start_input,
   input wire reverse_start_input,
   input wire comm_fwd_cmd,
   input wire comm_rev_cmd,
   // stop and mode keys
   input wire panel_stop_key,
   input wire unit_stop_key,
   input wire panel_mode_key,
   input wire unit_mode_key,
   // drive commands
   output reg run_fwd_r,
   output reg run_rev_r,
   output reg stop_ramp_r,
   output reg stop_coast_r,
   output reg panel_stop_state_r,
   output reg unit_is_source_r,
   // held parameters
   output reg [15:0] write_protect_policy_r,
   output reg [15:0] rotation_inhibit_select_r,
   output reg [15:0] parameter_visibility_select_r,
   output reg [15:0] keypad_command_source_select_r,
   output reg [15:0] stop_behaviour_select_r,
   output reg [15:0] reset_and_stop_select_r
);
   // ****************************************
   // classification
   // ****************************************
   wire exempt;
   wire run_locked;
   wire any_time;
   wire simple;
   pag_param_class u_class (
      .pnum(req_pnum),
      .unit_fitted(unit_fitted),
      .exempt(exempt),
      .run_locked(run_locked),
      .any_time(any_time),
      .simple(simple)
   );
   // ****************************************
   // access decision
   // ****************************************
   reg is_held;
   reg [15:0] held_val;
   reg visible;
   reg value_ok;
   reg wr_ok;
   reg clr_ok;
   reg ext_vis;
   reg stopped_keypad;
   always @* begin
      ext_vis = (parameter_visibility_select_r == `PAG_VIS_EXTENDED);
      stopped_keypad = !motor_running && (op_mode == `PAG_MODE_KEYPAD);
      is_held = 1'b1;
      held_val = 16'h0000;
      case (req_pnum)
         `PAG_PN_RESET_SEL: held_val = reset_and_stop_select_r;
         `PAG_PN_WR_POLICY: held_val = write_protect_policy_r;
         `PAG_PN_ROT_INHIBIT: held_val = rotation_inhibit_select_r;
         `PAG_PN_VISIBILITY: held_val = parameter_visibility_select_r;
         `PAG_PN_STOP_BEHAV: held_val = stop_behaviour_select_r;
         `PAG_PN_CMD_SRC: held_val = keypad_command_source_select_r;
         default: is_held = 1'b0;
      endcase
      // serial reads ignore visibility unless serial owns keypad commands
      if (req_src == `PAG_SRC_SERIAL) begin
         visible = simple || ext_vis ||
            (keypad_command_source_select_r != `PAG_CMD_SRC_SERIAL);
      end else begin
         visible = simple || ext_vis;
      end
      // policy, rotation inhibit and visibility writes are range checked; the other held values are taken as written
      case (req_pnum)
         `PAG_PN_WR_POLICY: value_ok = (req_wdata <= `PAG_POL_FREE);
         `PAG_PN_ROT_INHIBIT: value_ok = (req_wdata <= `PAG_ROT_NO_FWD);
         `PAG_PN_VISIBILITY: value_ok = (req_wdata == `PAG_VIS_EXTENDED) || (req_wdata == `PAG_V_NONE);
         default: value_ok = 1'b1;
      endcase
      if (write_protect_policy_r == `PAG_POL_INHIBIT) begin
         wr_ok = exempt;
      end else if (write_protect_policy_r == `PAG_POL_FREE) begin
         wr_ok = !(motor_running && run_locked);
      end else begin
         wr_ok = stopped_keypad || any_time;
      end
      if (req_pnum == `PAG_PN_WR_POLICY) begin
         wr_ok = 1'b1;
      end
      if ((req_pnum == `PAG_PN_WR_POLICY) || (req_pnum == `PAG_PN_ROT_INHIBIT)) begin
         wr_ok = wr_ok && ext_vis;
      end
      wr_ok = wr_ok && visible && value_ok;
      // all-parameter clear is never allowed while the motor turns
      if (write_protect_policy_r == `PAG_POL_INHIBIT) begin
         clr_ok = 1'b0;
      end else if (write_protect_policy_r == `PAG_POL_FREE) begin
         clr_ok = !motor_running;
      end else begin
         clr_ok = stopped_keypad;
      end
   end
   wire is_clr = req_clear || req_all_clear;
   wire acc_write = req_valid && !is_clr && req_write && wr_ok;
   // ****************************************
   // request handling and held parameters
   // ****************************************
   always @(posedge core_clk) begin
      if (srst) begin
         rsp_valid_r <= 1'b0;
         rsp_err_r <= 1'b0;
         rsp_rdata_r <= 16'h0000;
         store_we_r <= 1'b0;
         store_pnum_r <= 10'h000;
         store_wdata_r <= 16'h0000;
         param_clear_r <= 1'b0;
         all_clear_r <= 1'b0;
         write_protect_policy_r <= `PAG_POL_STOP_ONLY;
         rotation_inhibit_select_r <= `PAG_ROT_BOTH;
         parameter_visibility_select_r <= `PAG_V_NONE;
         keypad_command_source_select_r <= `PAG_V_NONE;
         stop_behaviour_select_r <= `PAG_V_NONE;
         reset_and_stop_select_r <= `PAG_RSEL_RESET;
      end else begin
         rsp_valid_r <= req_valid;
         rsp_err_r <= 1'b0;
         rsp_rdata_r <= 16'h0000;
         store_we_r <= 1'b0;
         param_clear_r <= 1'b0;
         all_clear_r <= 1'b0;
         if (req_valid) begin
            if (is_clr) begin
               if (clr_ok) begin
                  param_clear_r <= req_clear && !req_all_clear;
                  all_clear_r <= req_all_clear;
                  // cleared drive settings fall back to their reset values
                  rotation_inhibit_select_r <= `PAG_ROT_BOTH;
                  stop_behaviour_select_r <= `PAG_V_NONE;
                  keypad_command_source_select_r <= `PAG_V_NONE;
                  if (req_all_clear) begin
                     write_protect_policy_r <= `PAG_POL_STOP_ONLY;
                     parameter_visibility_select_r <= `PAG_V_NONE;
                     reset_and_stop_select_r <= `PAG_RSEL_RESET;
                  end
               end else begin
                  rsp_err_r <= 1'b1;
               end
            end else if (req_write) begin
               if (!wr_ok) begin
                  rsp_err_r <= 1'b1;
               end else if (is_held) begin
                  case (req_pnum)
                     `PAG_PN_RESET_SEL: reset_and_stop_select_r <= req_wdata;
                     `PAG_PN_WR_POLICY: write_protect_policy_r <= req_wdata;
                     `PAG_PN_ROT_INHIBIT: rotation_inhibit_select_r <= req_wdata;
                     `PAG_PN_VISIBILITY: parameter_visibility_select_r <= req_wdata;
                     `PAG_PN_STOP_BEHAV: stop_behaviour_select_r <= req_wdata;
                     default: keypad_command_source_select_r <= req_wdata;
                  endcase
               end
            end else if (!visible) begin
               rsp_err_r <= 1'b1;
            end else begin
               rsp_rdata_r <= is_held ? held_val : store_rdata;
            end
         end
         if (acc_write && !is_held) begin
            store_we_r <= 1'b1;
            store_pnum_r <= req_pnum;
            store_wdata_r <= req_wdata;
         end
      end
   end
   // ****************************************
   // command source and rotation inhibit
   // ****************************************
   reg unit_src;
   reg want_fwd;
   reg want_rev;
   reg fwd_allowed;
   reg rev_allowed;
   always @* begin
      // default selection: a fitted external unit takes priority over the panel
      unit_src = unit_fitted && (keypad_command_source_select_r == `PAG_V_NONE);
      case (op_mode)
         `PAG_MODE_KEYPAD: begin
            if (keypad_command_source_select_r == `PAG_CMD_SRC_SERIAL) begin
               want_fwd = comm_fwd_cmd;
               want_rev = comm_rev_cmd;
            end else if (unit_src) begin
               want_fwd = unit_fwd_key;
               want_rev = unit_rev_key;
            end else begin
               want_fwd = panel_fwd_key;
               want_rev = panel_rev_key;
            end
         end
         `PAG_MODE_EXT: begin
            want_fwd = forward_start_input;
            want_rev = reverse_start_input;
         end
         default: begin
            want_fwd = comm_fwd_cmd;
            want_rev = comm_rev_cmd;
         end
      endcase
      fwd_allowed = (rotation_inhibit_select_r != `PAG_ROT_NO_FWD);
      rev_allowed = (rotation_inhibit_select_r != `PAG_ROT_NO_REV);
   end
   // ****************************************
   // panel stop
   // ****************************************
   reg ps_by_unit_r;
   reg ps_enable;
   reg key_stop;
   reg key_from_unit;
   reg enter_ps;
   reg plain_stop;
   reg leave_ps;
   reg starts_on;
   always @* begin
      ps_enable = (reset_and_stop_select_r > `PAG_RSEL_NO_PS_MAX);
      key_stop = panel_stop_key || unit_stop_key;
      key_from_unit = unit_stop_key;
      starts_on = forward_start_input || reverse_start_input;
      enter_ps = 1'b0;
      plain_stop = 1'b0;
      if (key_stop) begin
         if (!ps_enable) begin
            plain_stop = (op_mode == `PAG_MODE_KEYPAD);
         end else if (op_mode != `PAG_MODE_KEYPAD) begin
            enter_ps = 1'b1;
         end else if (key_from_unit != unit_src) begin
            enter_ps = 1'b1;
         end else begin
            plain_stop = 1'b1;
         end
      end
      // only the unit that made the stop may release it, once stopped with starts off
      leave_ps = panel_stop_state_r && !motor_running && !starts_on &&
         (ps_by_unit_r ? unit_mode_key : panel_mode_key);
   end
   always @(posedge core_clk) begin
      if (srst) begin
         panel_stop_state_r <= 1'b0;
         ps_by_unit_r <= 1'b0;
         stop_ramp_r <= 1'b0;
         stop_coast_r <= 1'b0;
         run_fwd_r <= 1'b0;
         run_rev_r <= 1'b0;
         unit_is_source_r <= 1'b0;
      end else begin
         unit_is_source_r <= unit_src;
         if (fault_clear_input) begin
            panel_stop_state_r <= 1'b0;
         end else if (enter_ps && !panel_stop_state_r) begin
            panel_stop_state_r <= 1'b1;
            ps_by_unit_r <= key_from_unit;
         end else if (leave_ps) begin
            panel_stop_state_r <= 1'b0;
         end
         // a panel stop in external mode always ramps, whatever the stop setting
         if (enter_ps || (panel_stop_state_r && !leave_ps && !fault_clear_input)) begin
            stop_ramp_r <= (op_mode == `PAG_MODE_EXT) ||
               (stop_behaviour_select_r == `PAG_V_NONE);
            stop_coast_r <= (op_mode != `PAG_MODE_EXT) &&
               (stop_behaviour_select_r != `PAG_V_NONE);
         end else begin
            stop_ramp_r <= plain_stop && (stop_behaviour_select_r == `PAG_V_NONE);
            stop_coast_r <= plain_stop && (stop_behaviour_select_r != `PAG_V_NONE);
         end
         // both directions at once resolve to no run; held off during a stop
         if (panel_stop_state_r || enter_ps || plain_stop) begin
            run_fwd_r <= 1'b0;
            run_rev_r <= 1'b0;
         end else begin
            run_fwd_r <= want_fwd && !want_rev && fwd_allowed;
            run_rev_r <= want_rev && !want_fwd && rev_allowed;
         end
      end
   end
endmodule // pag_guard

// File: logic/pag_defs.vh
// constants for the parameter access guard
`ifndef PAG_DEFS_VH
`define PAG_DEFS_VH
// ****************************************
// parameter numbers
// ****************************************
`define PAG_PN_JOG_SPEED 10'h00F
`define PAG_PN_JOG_RAMP 10'h010
`define PAG_PN_STALL_LVL 10'h016
`define PAG_PN_RUN_KEY_DIR 10'h028
`define PAG_PN_STALL2_CUR 10'h030
`define PAG_PN_RESET_SEL 10'h04B
`define PAG_PN_WR_POLICY 10'h04D
`define PAG_PN_ROT_INHIBIT 10'h04E
`define PAG_PN_OP_MODE 10'h04F
`define PAG_PN_VISIBILITY 10'h0A0
`define PAG_PN_IN_TERM_LO 10'h0B2
`define PAG_PN_IN_TERM_HI 10'h0B6
`define PAG_PN_OUT_TERM_A 10'h0BE
`define PAG_PN_OUT_TERM_B 10'h0C0
`define PAG_PN_STOP_BEHAV 10'h0FA
`define PAG_PN_PWD_LEVEL 10'h128
`define PAG_PN_PWD_LOCK 10'h129
`define PAG_PN_CMD_SRC 10'h227
`define PAG_PN_PTC_LEVEL 10'h231
`define PAG_PN_BRAKE_TIME 10'h2E0
`define PAG_PN_PM_BOOST 10'h311
`define PAG_PN_DC_BOOST 10'h31B
`define PAG_PN_CTRL_METHOD 10'h320
`define PAG_PN_CONTRAST 10'h3DF
`define PAG_PN_FAULT_INIT 10'h3E5
`define PAG_PN_AUTO_SET 10'h3E7
`define PAG_SIMPLE_LAST 10'h009
// ****************************************
// values and reset values
// ****************************************
`define PAG_V_NONE 16'h270F
`define PAG_POL_STOP_ONLY 16'h0000
`define PAG_POL_INHIBIT 16'h0001
`define PAG_POL_FREE 16'h0002
`define PAG_ROT_BOTH 16'h0000
`define PAG_ROT_NO_REV 16'h0001
`define PAG_ROT_NO_FWD 16'h0002
`define PAG_VIS_EXTENDED 16'h0000
`define PAG_CMD_SRC_SERIAL 16'h0002
`define PAG_RSEL_NO_PS_MAX 16'h0003
`define PAG_RSEL_RESET 16'h000E
// ****************************************
// encodings
// ****************************************
`define PAG_MODE_KEYPAD 2'h0
`define PAG_MODE_EXT 2'h1
`define PAG_MODE_NET 2'h2
`define PAG_SRC_PANEL 2'h0
`define PAG_SRC_UNIT 2'h1
`define PAG_SRC_SERIAL 2'h2
`endif

// File: logic/pag_param_class.v
// classifies a parameter number into the access-policy lists
`include "pag_defs.vh"
module pag_param_class (
   // query
   input wire [9:0] pnum,
   input wire unit_fitted,
   // classes
   output reg exempt,
   output reg run_locked,
   output reg any_time,
   output reg simple
);
   always @* begin
      // writable even with writes inhibited
      exempt = (pnum == `PAG_PN_STALL_LVL) || (pnum == `PAG_PN_RESET_SEL) ||
         (pnum == `PAG_PN_WR_POLICY) || (pnum == `PAG_PN_OP_MODE) ||
         (pnum == `PAG_PN_VISIBILITY) || (pnum == `PAG_PN_PWD_LEVEL) ||
         (pnum == `PAG_PN_PWD_LOCK) || (pnum == `PAG_PN_FAULT_INIT);
      // refused while running under the free write policy
      run_locked = (pnum == `PAG_PN_RUN_KEY_DIR) || (pnum == `PAG_PN_STALL2_CUR) ||
         (pnum == `PAG_PN_OP_MODE) ||
         ((pnum >= `PAG_PN_IN_TERM_LO) && (pnum <= `PAG_PN_IN_TERM_HI)) ||
         (pnum == `PAG_PN_OUT_TERM_A) || (pnum == `PAG_PN_OUT_TERM_B) ||
         (pnum == `PAG_PN_PTC_LEVEL) || (pnum == `PAG_PN_BRAKE_TIME) ||
         (pnum == `PAG_PN_PM_BOOST) || (pnum == `PAG_PN_DC_BOOST) ||
         (pnum == `PAG_PN_CTRL_METHOD) || (pnum == `PAG_PN_AUTO_SET);
      // policy and visibility may change in any mode, running or not
      any_time = (pnum == `PAG_PN_WR_POLICY) || (pnum == `PAG_PN_VISIBILITY);
      simple = (pnum <= `PAG_SIMPLE_LAST) || (pnum == `PAG_PN_VISIBILITY);
      if (unit_fitted && ((pnum == `PAG_PN_JOG_SPEED) || (pnum == `PAG_PN_JOG_RAMP) ||
         (pnum == `PAG_PN_CONTRAST))) begin
         simple = 1'b1;
      end
   end
endmodule // pag_param_class

// File: tb/pag_guard_chk.sv
// assertion checker for the parameter access guard
module pag_guard_chk (
   // clock and reset
   input logic core_clk,
   input logic srst,
   // request and answer
   input logic req_valid,
   input logic req_write,
   input logic req_clear,
   input logic req_all_clear,
   input logic [9:0] req_pnum,
   input logic [15:0] req_wdata,
   input logic rsp_valid_r,
   input logic rsp_err_r,
   input logic store_we_r,
   input logic param_clear_r,
   input logic all_clear_r,
   // drive side
   input logic [1:0] op_mode,
   input logic fault_clear_input,
   input logic run_fwd_r,
   input logic run_rev_r,
   input logic stop_ramp_r,
   input logic stop_coast_r,
   input logic panel_stop_state_r,
   // held parameters
   input logic [15:0] write_protect_policy_r,
   input logic [15:0] rotation_inhibit_select_r,
   input logic [15:0] parameter_visibility_select_r,
   input logic [15:0] reset_and_stop_select_r
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);
   logic plain_wr;
   assign plain_wr = req_valid && req_write && !req_clear && !req_all_clear;
   a_answer_next: assert property (req_valid |=> rsp_valid_r)
      else $error("request got no answer");
   a_inhibit_write: assert property (plain_wr && write_protect_policy_r == 16'h0001 && req_pnum == 10'h001
      |=> rsp_err_r && !store_we_r) else $error("write taken under inhibit");
   a_inhibit_clear: assert property (req_valid && (req_clear || req_all_clear) && write_protect_policy_r == 16'h0001
      |=> !param_clear_r && !all_clear_r) else $error("clear taken under inhibit");
   a_policy_write: assert property (plain_wr && req_pnum == 10'h04D && parameter_visibility_select_r == 16'h0000
      && req_wdata <= 16'h0002 |=> !rsp_err_r && write_protect_policy_r == $past(req_wdata))
      else $error("policy write not taken");
   a_hidden_rotation: assert property (plain_wr && req_pnum == 10'h04E && parameter_visibility_select_r != 16'h0000
      |=> rsp_err_r && $stable(rotation_inhibit_select_r)) else $error("hidden rotation write taken");
   a_no_reverse: assert property (run_rev_r |-> $past(rotation_inhibit_select_r) != 16'h0001)
      else $error("reverse run while blocked");
   a_no_forward: assert property (run_fwd_r |-> $past(rotation_inhibit_select_r) != 16'h0002)
      else $error("forward run while blocked");
   a_fault_clear: assert property (fault_clear_input |=> !panel_stop_state_r)
      else $error("panel stop survived fault clear");
   a_ext_ramp: assert property ($rose(panel_stop_state_r) && $past(op_mode) == 2'h1
      |-> stop_ramp_r && !stop_coast_r) else $error("external panel stop did not ramp");
   a_low_select: assert property ($past(reset_and_stop_select_r) <= 16'h0003 |-> !$rose(panel_stop_state_r))
      else $error("panel stop with low reset selection");
endmodule // pag_guard_chk

// File: tb/pag_store_model.sv
// outer parameter store seen by the guard
module pag_store_model (
   // clock
   input logic core_clk,
   // write side
   input logic we,
   input logic [9:0] wr_pnum,
   input logic [15:0] wr_data,
   // read side
   input logic [9:0] rd_pnum,
   output logic [15:0] rd_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [1024];
   // seeded with a pattern so a wrong address shows in read data
   initial begin
      for (int i = 0; i < 1024; i++) begin
         mem[i] = 16'(i) ^ 16'hA5A5;
      end
   end
   always @(posedge core_clk) begin
      if (we) begin
         mem[wr_pnum] <= wr_data;
      end
   end
   assign rd_data = mem[rd_pnum];
endmodule // pag_store_model

// File: tb/tb_top.sv
// testbench top for the parameter access guard
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, srst, req_valid, req_write, req_clear, req_all_clear;
   logic [1:0] req_src, op_mode;
   logic [9:0] req_pnum, store_pnum_r;
   logic [15:0] req_wdata, store_rdata, rsp_rdata_r, store_wdata_r;
   logic motor_running, unit_fitted, fault_clear_input, panel_fwd_key, panel_rev_key, unit_fwd_key, unit_rev_key;
   logic forward_start_input, reverse_start_input, comm_fwd_cmd, comm_rev_cmd;
   logic panel_stop_key, unit_stop_key, panel_mode_key, unit_mode_key;
   logic rsp_valid_r, rsp_err_r, store_we_r, param_clear_r, all_clear_r, run_fwd_r, run_rev_r;
   logic stop_ramp_r, stop_coast_r, panel_stop_state_r, unit_is_source_r;
   logic [15:0] write_protect_policy_r, rotation_inhibit_select_r, parameter_visibility_select_r;
   logic [15:0] keypad_command_source_select_r, stop_behaviour_select_r, reset_and_stop_select_r;
   logic rv, re, sw;
   logic [15:0] rd;
   int errors, n_checks, cyc;
   logic [25:0] exempt [8] = '{{10'h016, 16'h0005}, {10'h04B, 16'h000E}, {10'h04D, 16'h0001}, {10'h04F, 16'h0000},
      {10'h0A0, 16'h0000}, {10'h128, 16'h270F}, {10'h129, 16'h270F}, {10'h3E5, 16'h0000}};
   logic [9:0] locked [14] = '{10'h028, 10'h030, 10'h04F, 10'h0B2, 10'h0B4, 10'h0B6, 10'h0BE, 10'h0C0,
      10'h231, 10'h2E0, 10'h311, 10'h31B, 10'h320, 10'h3E7};

   pag_guard dut_u (.*);
   pag_store_model store_u (.core_clk(core_clk), .we(store_we_r), .wr_pnum(store_pnum_r), .wr_data(store_wdata_r),
      .rd_pnum(req_pnum), .rd_data(store_rdata));

   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end

   // cut a hang short; the whole run needs under two hundred cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         report_and_stop;
      end
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // request held one cycle, answer taken at the next falling edge
   task acc(input logic w, input logic [1:0] c, input logic [1:0] s, input logic [9:0] p, input logic [15:0] d);
      @(negedge core_clk);
      req_valid = 1;
      req_write = w;
      {req_all_clear, req_clear} = c;
      req_src = s;
      req_pnum = p;
      req_wdata = d;
      @(negedge core_clk);
      {rv, re, sw, rd} = {rsp_valid_r, rsp_err_r, store_we_r, rsp_rdata_r};
      {req_valid, req_write, req_clear, req_all_clear} = '0;
      chk("answer", rv, 1);
   endtask

   task wr(input logic [9:0] p, input logic [15:0] d, input logic e);
      acc(1, 0, 0, p, d);
      chk("write refused", re, e);
   endtask

   task rdp(input logic [1:0] s, input logic [9:0] p, input logic e, input logic [15:0] x);
      acc(0, 0, s, p, 16'h0000);
      chk("read refused", re, e);
      chk("read data", rd, e ? 16'h0000 : x);
   endtask

   task automatic press(ref logic k);
      @(negedge core_clk);
      k = 1;
      @(negedge core_clk);
      k = 0;
      @(negedge core_clk);
   endtask

   task t_reset;
      chk("policy", write_protect_policy_r, 16'h0000);
      chk("visibility", parameter_visibility_select_r, 16'h270F);
      chk("cmd source", keypad_command_source_select_r, 16'h270F);
      chk("reset sel", reset_and_stop_select_r, 16'h000E);
      $display("t_reset done");
   endtask

   task t_stop_only;
      wr(10'h001, 16'h0033, 0);
      chk("store we", sw, 1);
      chk("store pnum", {6'h00, store_pnum_r}, 16'h0001);
      chk("store data", store_wdata_r, 16'h0033);
      motor_running = 1;
      wr(10'h001, 16'h0044, 1);
      chk("store we", sw, 0);
      motor_running = 0;
      op_mode = 2'h1;
      wr(10'h001, 16'h0044, 1);
      op_mode = 2'h0;
      rdp(0, 10'h001, 0, 16'h0033);
      $display("t_stop_only done");
   endtask

   task t_visibility;
      wr(10'h04D, 16'h0001, 1);
      wr(10'h04E, 16'h0001, 1);
      rdp(0, 10'h0B2, 1, 16'h0000);
      rdp(2, 10'h0B2, 0, 16'hA517);
      rdp(1, 10'h00F, 1, 16'h0000);
      unit_fitted = 1;
      rdp(1, 10'h00F, 0, 16'hA5AA);
      motor_running = 1;
      wr(10'h0A0, 16'h0000, 0);
      motor_running = 0;
      rdp(0, 10'h0B2, 0, 16'hA517);
      wr(10'h227, 16'h0002, 0);
      wr(10'h0A0, 16'h270F, 0);
      rdp(2, 10'h0B2, 1, 16'h0000);
      wr(10'h0A0, 16'h0000, 0);
      wr(10'h227, 16'h270F, 0);
      $display("t_visibility done");
   endtask

   task t_inhibit;
      wr(10'h04D, 16'h0001, 0);
      wr(10'h001, 16'h0005, 1);
      rdp(0, 10'h001, 0, 16'h0033);
      acc(0, 2'b01, 0, 10'h001, 16'h0000);
      chk("clear refused", re, 1);
      acc(0, 2'b10, 0, 10'h001, 16'h0000);
      chk("all clear refused", re, 1);
      foreach (exempt[i]) wr(exempt[i][25:16], exempt[i][15:0], 0);
      $display("t_inhibit done");
   endtask

   task t_free;
      wr(10'h04D, 16'h0002, 0);
      motor_running = 1;
      op_mode = 2'h1;
      wr(10'h001, 16'h0006, 0);
      foreach (locked[i]) wr(locked[i], 16'h0000, 1);
      wr(10'h04D, 16'h0000, 0);
      wr(10'h04D, 16'h0002, 0);
      motor_running = 0;
      op_mode = 2'h0;
      $display("t_free done");
   endtask

   // every source driven at once; the mode picks which one counts
   task t_rotation;
      for (int r = 0; r < 3; r++) begin
         wr(10'h04E, 16'(r), 0);
         for (int m = 0; m < 3; m++) begin
            for (int d = 0; d < 2; d++) begin
               op_mode = 2'(m);
               {panel_fwd_key, unit_fwd_key, forward_start_input, comm_fwd_cmd} = {4{d == 0}};
               {panel_rev_key, unit_rev_key, reverse_start_input, comm_rev_cmd} = {4{d == 1}};
               repeat (2) @(negedge core_clk);
               chk("forward run", run_fwd_r, d == 0 && r != 2);
               chk("reverse run", run_rev_r, d == 1 && r != 1);
            end
         end
      end
      {panel_fwd_key, unit_fwd_key, forward_start_input, comm_fwd_cmd} = '0;
      {panel_rev_key, unit_rev_key, reverse_start_input, comm_rev_cmd} = '0;
      op_mode = 2'h0;
      $display("t_rotation done");
   endtask

   task t_panel_stop;
      op_mode = 2'h1;
      wr(10'h0FA, 16'h0000, 0);
      press(unit_stop_key);
      chk("panel stop", panel_stop_state_r, 1);
      chk("ramp stop", {stop_ramp_r, stop_coast_r}, 16'h0002);
      forward_start_input = 1;
      press(unit_mode_key);
      chk("held with start on", {panel_stop_state_r, run_fwd_r}, 16'h0002);
      forward_start_input = 0;
      press(unit_mode_key);
      chk("mode key clears", panel_stop_state_r, 0);
      press(panel_stop_key);
      press(fault_clear_input);
      chk("fault clear", panel_stop_state_r, 0);
      op_mode = 2'h0;
      chk("unit is source", unit_is_source_r, 1);
      press(unit_stop_key);
      chk("source stop plain", panel_stop_state_r, 0);
      press(panel_stop_key);
      chk("other unit stop", panel_stop_state_r, 1);
      press(fault_clear_input);
      wr(10'h04B, 16'h0000, 0);
      op_mode = 2'h1;
      press(unit_stop_key);
      chk("low select no stop", panel_stop_state_r, 0);
      op_mode = 2'h0;
      acc(0, 2'b01, 0, 10'h001, 16'h0000);
      chk("clear taken", {re, param_clear_r, all_clear_r}, 16'h0002);
      $display("t_panel_stop done");
   endtask

   initial begin
      {req_valid, req_write, req_clear, req_all_clear, req_src, op_mode, req_pnum, req_wdata} = '0;
      {motor_running, unit_fitted, fault_clear_input, panel_fwd_key, panel_rev_key, unit_fwd_key} = '0;
      {unit_rev_key, forward_start_input, reverse_start_input, comm_fwd_cmd, comm_rev_cmd} = '0;
      {panel_stop_key, unit_stop_key, panel_mode_key, unit_mode_key, errors, n_checks, cyc} = '0;
      srst = 1;
      repeat (10) @(negedge core_clk);
      srst = 0;
      t_reset;
      t_stop_only;
      t_visibility;
      t_inhibit;
      t_free;
      t_rotation;
      t_panel_stop;
      report_and_stop;
   end
endmodule // tb_top

bind pag_guard pag_guard_chk chk_u (.*);
